// ==== logic/tcic_defines.svh ====
// Register map, field positions and reset values of the three channel input capture unit
`ifndef TCIC_DEFINES_SVH
`define TCIC_DEFINES_SVH

// ****************************************
// Sizes
// ****************************************
`define TCIC_NCH            3
`define TCIC_AW             9
`define TCIC_DW             32
`define TCIC_PRESCALE_W     8
`define TCIC_MODE_W         2

// ****************************************
// Register byte offsets
// ****************************************
`define TCIC_OFS_TIMER_CFG  9'h0E8
`define TCIC_OFS_CH0_CFG    9'h0F0
`define TCIC_OFS_CH1_CFG    9'h0F4
`define TCIC_OFS_CH2_CFG    9'h0F8
`define TCIC_OFS_CH0_VAL    9'h0FC
`define TCIC_OFS_CH1_VAL    9'h100
`define TCIC_OFS_CH2_VAL    9'h104
`define TCIC_OFS_EDGE_ST    9'h108
`define TCIC_OFS_INT_ST     9'h120
`define TCIC_OFS_INT_MASK   9'h124

// ****************************************
// Field positions
// ****************************************
`define TCIC_TIMER_EN_BIT   0
`define TCIC_CFG_EN_BIT     0
`define TCIC_CFG_MODE_LO    1
`define TCIC_CFG_MODE_HI    2
`define TCIC_CFG_PRE_LO     3
`define TCIC_CFG_PRE_HI     10
`define TCIC_CFG_INV_BIT    11
`define TCIC_CFG_SW_BIT     12
`define TCIC_MODE_FALL_BIT  0
`define TCIC_MODE_RISE_BIT  1

// ****************************************
// Reset values and constants
// ****************************************
`define TCIC_RST_WORD       32'h0000_0000
`define TCIC_NO_SLOT        2'h3
`define TCIC_HTRANS_BUSY_B  1

`endif

// ==== logic/tcic_pkg.sv ====
// Types shared by the capture unit and its channels
`include "tcic_defines.svh"

package tcic_pkg;

  // Per channel configuration as software programs it
  typedef struct packed {
    logic                          inv;
    logic [`TCIC_PRESCALE_W-1:0]   prescale;
    logic [`TCIC_MODE_W-1:0]       mode;
    logic                          en;
  } tcic_cfg_t;

  // State of one channel front end
  typedef struct packed {
    logic                          sync1;
    logic                          sync2;
    logic                          in_d;
    logic [`TCIC_PRESCALE_W-1:0]   cnt;
    logic                          ps;
    logic                          ps_d;
  } tcic_chan_state_t;

  // State of the whole unit
  typedef struct packed {
    logic [`TCIC_DW-1:0]                    timer;
    logic                                   timer_en;
    tcic_cfg_t [`TCIC_NCH-1:0]              cfg;
    logic [`TCIC_NCH-1:0][`TCIC_DW-1:0]     value;
    logic [`TCIC_NCH-1:0]                   last_edge;
    logic [`TCIC_NCH-1:0]                   int_st;
    logic [`TCIC_NCH-1:0]                   int_mask;
    logic                                   wr_pend;
    logic [`TCIC_AW-1:0]                    wr_addr;
    logic                                   ready;
    logic [`TCIC_DW-1:0]                    rdata;
    logic                                   irq;
  } tcic_state_t;

endpackage

// ==== logic/tcic_channel.sv ====
// One capture channel front end: synchroniser, inversion, prescaler and edge select
module tcic_channel
  import tcic_pkg::*;
(
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Capture pin and settings
  input  wire logic       pin,
  input  wire tcic_cfg_t  cfg,
  // Capture request toward the register file
  output logic            hw_capture,
  output logic            fall_edge
);

  tcic_chan_state_t s_reg;
  tcic_chan_state_t s_next;
  logic             in_inv;
  logic             in_rise;
  logic             in_fall;
  logic             ps_rise;
  logic             ps_fall;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    s_next       = s_reg;
    // First stage feeds only the second
    s_next.sync1 = pin;
    s_next.sync2 = s_reg.sync1;
    in_inv       = s_reg.sync2 ^ cfg.inv;
    s_next.in_d  = in_inv;
    in_rise      = in_inv & ~s_reg.in_d;
    in_fall      = ~in_inv & s_reg.in_d;
    // Counter held clear while disabled so a fresh enable starts a full ratio
    if (!cfg.en)
    begin
      s_next.cnt = '0;
      s_next.ps  = in_inv & (cfg.prescale == '0);
    end
    else if (in_rise)
    begin
      if (s_reg.cnt >= cfg.prescale)
      begin
        s_next.cnt = '0;
        s_next.ps  = 1'b1;
      end
      else
      begin
        s_next.cnt = (`TCIC_PRESCALE_W)'(s_reg.cnt + 1'b1);
      end
    end
    else if (in_fall)
    begin
      s_next.ps = 1'b0;
    end
    s_next.ps_d = s_reg.ps;
    ps_rise     = s_reg.ps & ~s_reg.ps_d & cfg.mode[`TCIC_MODE_RISE_BIT];
    ps_fall     = ~s_reg.ps & s_reg.ps_d & cfg.mode[`TCIC_MODE_FALL_BIT];
    hw_capture  = cfg.en & (ps_rise | ps_fall);
    fall_edge   = ps_fall;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

endmodule // tcic_channel

// ==== logic/tcic_top.sv ====
// Three channel input capture unit with AHB-Lite register slave and interrupt
//
// Behaviour
// - Hardware capture only while channel enabled
// - Invert bit flips input before prescaler
// - Prescale rising edges, ratio is field plus one
// - Edge select: bit0 falling, bit1 rising
// - Writing software bit forces immediate capture
// - Value register holds last captured timer
// - Status bit: zero rising, one falling
// - Three identical independently configured channels
// - Timer counts each clock while enabled
//
// Added by the designer: the AHB-Lite register port.
module tcic_top
  import tcic_pkg::*;
(
  // Clock and reset
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  // AHB-Lite slave
  input  wire logic                   hsel,
  input  wire logic [`TCIC_AW-1:0]    haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [`TCIC_DW-1:0]    hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic [`TCIC_DW-1:0]         hrdata,
  output logic                        hresp,
  // Capture pins
  input  wire logic                   capture_input_zero,
  input  wire logic                   capture_input_one,
  input  wire logic                   capture_input_two,
  // Interrupt
  output logic                        irq
);

  // ****************************************
  // Declarations
  // ****************************************
  tcic_state_t            s_reg;
  tcic_state_t            s_next;
  logic [`TCIC_NCH-1:0]   pins;
  logic [`TCIC_NCH-1:0]   hw_capture;
  logic [`TCIC_NCH-1:0]   fall_edge;
  logic [`TCIC_NCH-1:0]   force_capture;
  logic                   addr_phase;
  logic                   wr_word;
  logic [1:0]             wslot;

  assign pins = {capture_input_two, capture_input_one, capture_input_zero};

  // ****************************************
  // Address decode helpers
  // ****************************************
  // Channel of a configuration register, or no slot
  function automatic logic [1:0] cfg_slot(input logic [`TCIC_AW-1:0] a);
    logic [1:0] r;
    r = `TCIC_NO_SLOT;
    unique case (a)
      `TCIC_OFS_CH0_CFG: r = 2'h0;
      `TCIC_OFS_CH1_CFG: r = 2'h1;
      `TCIC_OFS_CH2_CFG: r = 2'h2;
      default:           r = `TCIC_NO_SLOT;
    endcase
    return r;
  endfunction

  // Channel of a captured value register, or no slot
  function automatic logic [1:0] val_slot(input logic [`TCIC_AW-1:0] a);
    logic [1:0] r;
    r = `TCIC_NO_SLOT;
    unique case (a)
      `TCIC_OFS_CH0_VAL: r = 2'h0;
      `TCIC_OFS_CH1_VAL: r = 2'h1;
      `TCIC_OFS_CH2_VAL: r = 2'h2;
      default:           r = `TCIC_NO_SLOT;
    endcase
    return r;
  endfunction

  // Packs a channel configuration into its register word
  function automatic logic [`TCIC_DW-1:0] cfg_word(input tcic_cfg_t c);
    logic [`TCIC_DW-1:0] w;
    w = `TCIC_RST_WORD;
    w[`TCIC_CFG_EN_BIT]                     = c.en;
    w[`TCIC_CFG_MODE_HI:`TCIC_CFG_MODE_LO]  = c.mode;
    w[`TCIC_CFG_PRE_HI:`TCIC_CFG_PRE_LO]    = c.prescale;
    w[`TCIC_CFG_INV_BIT]                    = c.inv;
    return w;
  endfunction

  // Read mux over a state image
  function automatic logic [`TCIC_DW-1:0] read_word(input tcic_state_t t, input logic [`TCIC_AW-1:0] a);
    logic [`TCIC_DW-1:0] w;
    logic [1:0]          cs;
    logic [1:0]          vs;
    w  = `TCIC_RST_WORD;
    cs = cfg_slot(a);
    vs = val_slot(a);
    if (cs != `TCIC_NO_SLOT)
    begin
      // Software capture bit always reads zero
      w = cfg_word(t.cfg[cs]);
    end
    else if (vs != `TCIC_NO_SLOT)
    begin
      w = t.value[vs];
    end
    else
    begin
      unique case (a)
        `TCIC_OFS_TIMER_CFG: w[`TCIC_TIMER_EN_BIT] = t.timer_en;
        `TCIC_OFS_EDGE_ST:   w[`TCIC_NCH-1:0]      = t.last_edge;
        `TCIC_OFS_INT_ST:    w[`TCIC_NCH-1:0]      = t.int_st;
        `TCIC_OFS_INT_MASK:  w[`TCIC_NCH-1:0]      = t.int_mask;
        // Unmapped addresses read as zero with an OKAY answer
        default:             w                     = `TCIC_RST_WORD;
      endcase
    end
    return w;
  endfunction

  // ****************************************
  // Capture channels
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < `TCIC_NCH; gi = gi + 1)
    begin : g_chan
      tcic_channel u_chan (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .pin        (pins[gi]),
        .cfg        (s_reg.cfg[gi]),
        .hw_capture (hw_capture[gi]),
        .fall_edge  (fall_edge[gi])
      );
    end
  endgenerate

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    s_next        = s_reg;
    force_capture = '0;
    wslot         = `TCIC_NO_SLOT;
    // Zero wait states: every transfer finishes in its first data cycle
    s_next.ready  = 1'b1;
    addr_phase    = hsel & hready & htrans[`TCIC_HTRANS_BUSY_B];
    // Only whole word transfers change registers
    wr_word       = s_reg.wr_pend;

    // Free running capture timer
    if (s_reg.timer_en)
    begin
      s_next.timer = s_reg.timer + 32'h0000_0001;
    end

    // Data phase of a write
    if (wr_word)
    begin
      wslot = cfg_slot(s_reg.wr_addr);
      if (wslot != `TCIC_NO_SLOT)
      begin
        s_next.cfg[wslot].en       = hwdata[`TCIC_CFG_EN_BIT];
        s_next.cfg[wslot].mode     = hwdata[`TCIC_CFG_MODE_HI:`TCIC_CFG_MODE_LO];
        s_next.cfg[wslot].prescale = hwdata[`TCIC_CFG_PRE_HI:`TCIC_CFG_PRE_LO];
        s_next.cfg[wslot].inv      = hwdata[`TCIC_CFG_INV_BIT];
        force_capture[wslot]       = hwdata[`TCIC_CFG_SW_BIT];
      end
      else
      begin
        unique case (s_reg.wr_addr)
          `TCIC_OFS_TIMER_CFG: s_next.timer_en = hwdata[`TCIC_TIMER_EN_BIT];
          `TCIC_OFS_INT_ST:    s_next.int_st   = s_reg.int_st & ~hwdata[`TCIC_NCH-1:0];
          `TCIC_OFS_INT_MASK:  s_next.int_mask = hwdata[`TCIC_NCH-1:0];
          // Read only and unmapped words ignore writes
          default:             s_next.int_mask = s_reg.int_mask;
        endcase
      end
    end

    // Captures come after the clear so a set in the same cycle wins
    for (int i = 0; i < `TCIC_NCH; i++)
    begin
      if (hw_capture[i] | force_capture[i])
      begin
        s_next.value[i]  = s_reg.timer;
        s_next.int_st[i] = 1'b1;
        // A forced capture has no edge, so the last edge bit stays
        if (hw_capture[i])
        begin
          s_next.last_edge[i] = fall_edge[i];
        end
      end
    end

    // Address phase: latch writes, answer reads in the next cycle
    s_next.wr_pend = addr_phase & hwrite & (hsize == 3'h2);
    if (addr_phase)
    begin
      s_next.wr_addr = haddr;
    end
    // Read data taken from the updated image, so a read right after a write sees it
    if (addr_phase & ~hwrite)
    begin
      s_next.rdata = read_word(s_next, haddr);
    end
    else
    begin
      s_next.rdata = `TCIC_RST_WORD;
    end

    s_next.irq = |(s_next.int_st & s_next.int_mask);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_reg       <= '0;
      s_reg.ready <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign hreadyout = s_reg.ready;
  assign hrdata    = s_reg.rdata;
  assign hresp     = 1'b0;
  assign irq       = s_reg.irq;

endmodule // tcic_top

// ==== bench/tcic_checker.sv ====
// Port assertions of the three channel input capture unit
`include "tcic_defines.svh"
module tcic_checker (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Register bus
  input wire logic        hsel,
  input wire logic [8:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // Interrupt
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic             ap_v, ap_w, ten_sh;
  logic [8:0]       ap_a;
  logic [2:0]       msk_sh;
  logic [2:0][11:0] cfg_sh;
  wire              rd_v = ap_v && !ap_w;
  wire              wr_v = ap_v && ap_w;
  wire              cfg_a = ap_a >= 9'h0F0 && ap_a <= 9'h0F8;
  // Shadow of software writes; hready is always high, so no stall handling
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_v   <= 1'b0;
      ap_w   <= 1'b0;
      ap_a   <= 9'h000;
      ten_sh <= 1'b0;
      msk_sh <= 3'h0;
      cfg_sh <= '0;
    end
    else
    begin
      ap_v <= hsel && htrans[1];
      ap_w <= hwrite;
      ap_a <= haddr;
      if (wr_v && cfg_a)
        cfg_sh[ap_a[3:2]] <= hwdata[11:0];
      if (wr_v && ap_a == `TCIC_OFS_INT_MASK)
        msk_sh <= hwdata[2:0];
      if (wr_v && ap_a == `TCIC_OFS_TIMER_CFG)
        ten_sh <= hwdata[0];
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ****************************************
  // Assertions
  // ****************************************
  AST_READY_HIGH: assert property (hreadyout)
    else $error("wait state seen");
  AST_RESP_OKAY: assert property (!hresp)
    else $error("error response seen");
  AST_RDATA_IDLE: assert property (!rd_v |-> hrdata == 32'h0)
    else $error("read data outside a read");
  AST_CFG_READ: assert property (rd_v && cfg_a |-> hrdata == {20'h0, cfg_sh[ap_a[3:2]]})
    else $error("config read back wrong");
  AST_TIMER_READ: assert property (rd_v && ap_a == `TCIC_OFS_TIMER_CFG |-> hrdata == {31'h0, ten_sh})
    else $error("timer enable read back wrong");
  AST_EDGE_READ: assert property (rd_v && ap_a == `TCIC_OFS_EDGE_ST |-> hrdata[31:3] == 29'h0)
    else $error("edge status upper bits set");
  AST_MASK_READ: assert property (rd_v && ap_a == `TCIC_OFS_INT_MASK |-> hrdata == {29'h0, msk_sh})
    else $error("mask read back wrong");
  AST_IRQ_MASKED: assert property (msk_sh == 3'h0 && $past(msk_sh) == 3'h0 |-> !irq)
    else $error("interrupt with all masked");
  AST_SW_IRQ: assert property (wr_v && cfg_a && hwdata[12] && msk_sh[ap_a[3:2]] |-> ##[1:2] irq)
    else $error("forced capture raised no interrupt");
endmodule // tcic_checker

bind tcic_top tcic_checker u_tcic_checker (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hreadyout, .hrdata, .hresp, .irq);

// ==== bench/tcic_pin_model.sv ====
// Behavioural source of the three external capture signals
module tcic_pin_model (
  // Clock and cycle count of the bench
  input wire logic        hclk,
  input wire logic [31:0] cyc,
  // Capture signals
  output logic [2:0]      pins
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pins = 3'h0;
  // Change lands just after a rising edge; the design still treats the pins as asynchronous; caller keeps hold >= 3
  task automatic set_pin(input int ch, input logic lvl, input int hold, output int at);
    @(posedge hclk);
    pins[ch] <= lvl;
    at = int'(cyc);
    repeat (hold) @(posedge hclk);
  endtask
endmodule // tcic_pin_model

// ==== bench/tcic_tb_top.sv ====
// Self-checking bench of the three channel input capture unit
`include "tcic_defines.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module tcic_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, irq;
  logic [8:0]  haddr = 9'h000;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2, pins, eb = 3'h0;
  logic [31:0] hwdata = 32'h0, hrdata, cyc = 32'h0, r, q;
  logic [8:0]  ra [11] = '{9'h0E8, 9'h0F0, 9'h0F4, 9'h0F8, 9'h0FC, 9'h100, 9'h104, 9'h108, 9'h120, 9'h124, 9'h010};
  int          error_cnt = 0, n_tests = 0, seed = 32027;
  tcic_top u_tcic_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hrdata, .hresp, .capture_input_zero(pins[0]), .capture_input_one(pins[1]),
    .capture_input_two(pins[2]), .irq);
  tcic_pin_model u_tcic_pin_model (.hclk, .cyc, .pins);
  always #25 hclk = ~hclk;
  always @(posedge hclk)
  begin
    cyc <= cyc + 32'h1;
    if (cyc == 32'd8000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end
  // ****************************************
  // Bus and scenario tasks
  // ****************************************
  // Sampling at the falling edge gives what the next rising edge sees, free of races
  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d, output logic [31:0] v);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
    @(posedge hclk);
  endtask
  task automatic trial(input int i);
    int          ch, p, t, tp, en, inv, rises;
    logic [1:0]  m;
    logic [8:0]  ca, va;
    logic [31:0] v, vp, cw;
    logic        ps, cap;
    ch = i % 3;
    m = 2'(1 + (i / 3) % 3);
    p = $unsigned($random(seed)) % 3;
    inv = $unsigned($random(seed)) % 2;
    en = (i % 4) != 3;
    ca = `TCIC_OFS_CH0_CFG + 9'(4 * ch);
    va = `TCIC_OFS_CH0_VAL + 9'(4 * ch);
    cw = {20'h0, 1'(inv), 8'(p), m, 1'(en)};
    bus(1'b1, ca, cw & 32'h0000_0FFE, q);
    u_tcic_pin_model.set_pin(ch, 1'(inv), 5, t);
    bus(1'b0, va, 32'h0, vp);
    bus(1'b1, ca, cw | 32'h0000_1000, q);
    bus(1'b0, ca, 32'h0, v);
    `CHK(v, cw)
    bus(1'b0, va, 32'h0, v);
    `CHK(v != vp, 1'b1)
    bus(1'b0, `TCIC_OFS_EDGE_ST, 32'h0, r);
    `CHK(r[2:0], eb)
    vp = v;
    tp = -1;
    rises = 0;
    ps = 1'b0;
    for (int k = 0; k < 2 * p + 4; k++)
    begin
      u_tcic_pin_model.set_pin(ch, 1'((k % 2 == 0) ^ inv), 5 + $unsigned($random(seed)) % 3, t);
      if (k % 2 == 0)
      begin
        rises++;
        ps = ps || (rises % (p + 1) == 0);
        cap = (rises % (p + 1) == 0) && m[1];
      end
      else
      begin
        cap = ps && m[0];
        ps = 1'b0;
      end
      bus(1'b0, va, 32'h0, v);
      bus(1'b0, `TCIC_OFS_EDGE_ST, 32'h0, r);
      if (cap && en != 0)
      begin
        eb[ch] = 1'(k % 2);
        if (tp >= 0)
          `CHK(v - vp, 32'(t - tp))
        tp = t;
      end
      else
        `CHK(v, vp)
      `CHK(r[2:0], eb)
      vp = v;
    end
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (ra[j])
    begin
      bus(1'b0, ra[j], 32'h0, r);
      `CHK(r, 32'h0)
    end
    bus(1'b1, `TCIC_OFS_TIMER_CFG, 32'h1, q);
    bus(1'b1, `TCIC_OFS_INT_MASK, 32'h7, q);
    for (int i = 0; i < 12; i++)
      trial(i);
    // Raise an event while masked, then unmask and clear it
    bus(1'b1, `TCIC_OFS_INT_MASK, 32'h0, q);
    bus(1'b1, `TCIC_OFS_INT_ST, 32'h7, q);
    bus(1'b1, `TCIC_OFS_CH0_CFG, 32'h0000_1000, q);
    bus(1'b0, `TCIC_OFS_INT_ST, 32'h0, r);
    `CHK(r, 32'h1)
    bus(1'b1, `TCIC_OFS_INT_MASK, 32'h1, q);
    repeat (2) @(negedge hclk);
    `CHK(irq, 1'b1)
    @(posedge hclk);
    bus(1'b1, `TCIC_OFS_INT_ST, 32'h1, q);
    repeat (2) @(negedge hclk);
    `CHK(irq, 1'b0)
    @(posedge hclk);
    // Stopped timer: two forced captures agree, and the value register ignores writes
    bus(1'b1, `TCIC_OFS_TIMER_CFG, 32'h0, q);
    bus(1'b1, `TCIC_OFS_CH0_CFG, 32'h0000_1000, q);
    bus(1'b0, `TCIC_OFS_CH0_VAL, 32'h0, r);
    bus(1'b1, `TCIC_OFS_CH0_CFG, 32'h0000_1000, q);
    bus(1'b1, `TCIC_OFS_CH0_VAL, 32'hFFFF_FFFF, q);
    bus(1'b0, `TCIC_OFS_CH0_VAL, 32'h0, q);
    `CHK(q, r)
    report_and_stop();
  end
endmodule // tcic_tb_top
